// ===== verilog/ics_top.sv
// Top: odd/even interleaved core storage control with shared request port
//
// Notes on behaviour
// - Odd addresses one unit, even the other
// - Each unit 16384 words, 128 by 128
// - Words 48 bits, all bits parallel
// - Read delivers word then restores it
// - Write clears location then stores word
// - Full reference takes 6.4 microseconds
// - Read data ready 2.2 microseconds after request
// - Cycles of both units may overlap
// - Written data passes the unit restore register
// - Address register stable for whole cycle
// - Control, arithmetic, I/O reach storage in turn through one shared request port
// - Select by coincident row and column drive
// - Read drive zeroes bits; sense pulse means one
// - Inhibit bits that stay zero on write
// - Sense sampled while read drive applied
// - Low address bit picks unit, 14 remain
// - Address loads from operand, program, channel
`timescale 1ns/1ns
module ics_top
  import ics_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req,
  input  wire logic              write,
  input  wire logic [1:0]        src_sel,
  input  wire logic [ADDR_W-1:0] operand_address_source,
  input  wire logic [ADDR_W-1:0] program_address_source,
  input  wire logic [ADDR_W-1:0] buffer_channel_address_source,
  input  wire logic [WORD_W-1:0] wdata,
  output logic                   accept,
  output logic                   refuse,
  output logic                   rvalid,
  output logic [WORD_W-1:0]      rdata,
  output logic                   odd_busy,
  output logic                   even_busy
);

  typedef struct packed {
    // Lengths of the running unit cycles, read only by the checks below
    logic [CNT_W-1:0]  odd_len;
    logic [CNT_W-1:0]  even_len;
    logic              accept;
    logic              refuse;
    logic              rvalid;
    logic [WORD_W-1:0] rdata;
    logic              odd_busy;
    logic              even_busy;
  } ics_top_s;

  ics_top_s st;
  ics_top_s next_st;

  logic [ADDR_W-1:0] sel_addr;
  logic              go_odd;
  logic              go_even;
  logic [1:0]        u_busy;
  logic [1:0]        u_rvalid;
  logic [WORD_W-1:0] u_rdata [2];
  logic [1:0]        u_req;
  logic [UADDR_W-1:0] loc_in;
  logic [LINE_W-1:0]  u_row [2];
  logic [LINE_W-1:0]  u_col [2];
  logic [1:0]         u_drive;
  logic [WORD_W-1:0]  u_inhibit [2];

  // Unit access latency as seen on the unit pins, and on the registered outputs
  localparam int ACC_DLY = ACCESS_CLKS + 1;
  localparam int OUT_DLY = ACCESS_CLKS + 2;

  // Pick the address source by transfer command
  always_comb begin
    case (ics_src_e'(src_sel))
      ICS_SRC_PROGRAM: sel_addr = program_address_source;
      ICS_SRC_CHANNEL: sel_addr = buffer_channel_address_source;
      default:         sel_addr = operand_address_source;
    endcase
  end

  // Unit 1 serves odd addresses, unit 0 even
  assign go_odd  = req && ics_is_odd(sel_addr) && !u_busy[1];
  assign go_even = req && !ics_is_odd(sel_addr) && !u_busy[0];
  assign u_req   = {go_odd, go_even};
  assign loc_in  = ics_local(sel_addr);

  for (genvar u = 0; u < 2; u++) begin : g_unit
    // Each unit runs its own sequence so the two overlap freely
    ics_unit u_store (
      .clk      (clk),
      .rst_n    (rst_n),
      .req      (u_req[u]),
      .write    (write),
      .addr     (loc_in),
      .wdata    (wdata),
      .busy     (u_busy[u]),
      .rvalid   (u_rvalid[u]),
      .rdata    (u_rdata[u]),
      .row_sel  (u_row[u]),
      .col_sel  (u_col[u]),
      .drive_on (u_drive[u]),
      .inhibit  (u_inhibit[u])
    );

    // Checks on the unit's own pins and its delivery to the outputs, whatever the other unit is doing
    unit_start_a: assert property (
      @(posedge clk) disable iff (!rst_n) u_req[u] |=> u_busy[u] && u_drive[u])
      else $error("unit did not start its drive");

    unit_sel_a: assert property (
      @(posedge clk) disable iff (!rst_n)
        u_req[u] |=> {u_row[u], u_col[u]} == $past(loc_in))
      else $error("row and column lines miss the address");

    sel_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
        u_busy[u] |=> !u_busy[u] || $stable({u_row[u], u_col[u]}))
      else $error("drive lines moved mid cycle");

    drive_busy_a: assert property (
      @(posedge clk) disable iff (!rst_n) u_drive[u] |-> u_busy[u])
      else $error("drive outside a cycle");

    inhibit_idle_a: assert property (
      @(posedge clk) disable iff (!rst_n) !u_busy[u] |-> !(|u_inhibit[u]))
      else $error("inhibit active outside a cycle");

    // Inhibit marks the zero bits of the word taken with the write request
    write_inhibit_a: assert property (
      @(posedge clk) disable iff (!rst_n)
        (u_req[u] && write) |-> ##ACC_DLY (u_inhibit[u] == ~$past(wdata, ACC_DLY)))
      else $error("inhibit does not match write word");

    read_lat_a: assert property (
      @(posedge clk) disable iff (!rst_n) (u_req[u] && !write) |-> ##ACC_DLY u_rvalid[u])
      else $error("unit read data late");

    write_quiet_a: assert property (
      @(posedge clk) disable iff (!rst_n) (u_req[u] && write) |-> ##ACC_DLY !u_rvalid[u])
      else $error("write cycle delivered data");

    rvalid_pulse_a: assert property (
      @(posedge clk) disable iff (!rst_n) u_rvalid[u] |=> !u_rvalid[u])
      else $error("unit read valid stood too long");

    deliver_a: assert property (
      @(posedge clk) disable iff (!rst_n) u_rvalid[u] |=> rvalid && rdata == $past(u_rdata[u]))
      else $error("unit word not delivered");
  end

  always_comb begin
    next_st           = st;
    next_st.accept    = go_odd | go_even;
    next_st.refuse    = req & ~(go_odd | go_even);
    next_st.rvalid    = |u_rvalid;
    // Both units cannot finish access in the same cycle unless requested together,
    // which the single request port forbids, so a plain select is safe
    next_st.rdata     = u_rvalid[1] ? u_rdata[1] : (u_rvalid[0] ? u_rdata[0] : st.rdata);
    next_st.odd_len   = u_busy[1] ? CNT_W'(st.odd_len + CNT_ONE) : CNT_ZERO;
    next_st.even_len  = u_busy[0] ? CNT_W'(st.even_len + CNT_ONE) : CNT_ZERO;
    next_st.odd_busy  = u_busy[1] | go_odd;
    next_st.even_busy = u_busy[0] | go_even;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign accept    = st.accept;
  assign refuse    = st.refuse;
  assign rvalid    = st.rvalid;
  assign rdata     = st.rdata;
  assign odd_busy  = st.odd_busy;
  assign even_busy = st.even_busy;

  // Read data appears a fixed access time after an accepted read
  access_time_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      ((go_odd || go_even) && !write) |-> ##OUT_DLY rvalid)
    else $error("read data late");

  unit_refuse_a: assert property (
    @(posedge clk) disable iff (!rst_n) (u_busy[1] && req && ics_is_odd(sel_addr))
      |=> refuse && !accept)
    else $error("busy odd unit took request");

  route_odd_a: assert property (
    @(posedge clk) disable iff (!rst_n) (req && sel_addr[UNIT_SEL_BIT] && !u_busy[1])
      |=> accept && odd_busy)
    else $error("odd address not taken by odd unit");

  route_even_a: assert property (
    @(posedge clk) disable iff (!rst_n) (req && !sel_addr[UNIT_SEL_BIT] && !u_busy[0])
      |=> accept && even_busy)
    else $error("even address not taken by even unit");

  cycle_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n) go_odd |=> u_busy[1] [*8])
    else $error("odd unit cycle ended early");

  overlap_a: assert property (
    @(posedge clk) disable iff (!rst_n) (u_busy[1] && req && !sel_addr[UNIT_SEL_BIT]
      && !u_busy[0]) |-> go_even)
    else $error("even unit blocked by odd cycle");

  accept_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n) (go_odd || go_even) |=> accept && !refuse)
    else $error("accept not reported");

  refuse_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n) (req && !go_odd && !go_even) |=> refuse)
    else $error("refusal not reported");

  one_unit_a: assert property (
    @(posedge clk) disable iff (!rst_n) !(go_odd && go_even))
    else $error("request sent to both units");

  flag_excl_a: assert property (
    @(posedge clk) disable iff (!rst_n) !(accept && refuse))
    else $error("accept and refuse together");

  // The word stands for the requester until the next delivery
  rdata_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n) !(|u_rvalid) |=> $stable(rdata))
    else $error("read word changed without delivery");

  src_prog_a: assert property (
    @(posedge clk) disable iff (!rst_n) (ics_src_e'(src_sel) == ICS_SRC_PROGRAM)
      |-> sel_addr == program_address_source)
    else $error("program address not selected");

  src_chan_a: assert property (
    @(posedge clk) disable iff (!rst_n) (ics_src_e'(src_sel) == ICS_SRC_CHANNEL)
      |-> sel_addr == buffer_channel_address_source)
    else $error("channel address not selected");

  src_oper_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      !(ics_src_e'(src_sel) inside {ICS_SRC_PROGRAM, ICS_SRC_CHANNEL})
      |-> sel_addr == operand_address_source)
    else $error("operand address not selected");

  // Counted lengths stand in for a long repetition, which the tools unroll
  odd_len_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      $fell(u_busy[1]) |-> st.odd_len == CNT_W'(CYCLE_CLKS))
    else $error("odd unit cycle length wrong");

  even_len_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      $fell(u_busy[0]) |-> st.even_len == CNT_W'(CYCLE_CLKS))
    else $error("even unit cycle length wrong");

  odd_free_a: assert property (
    @(posedge clk) disable iff (!rst_n) !(u_busy[1] || go_odd) |=> !odd_busy)
    else $error("odd busy shown while idle");

  even_free_a: assert property (
    @(posedge clk) disable iff (!rst_n) !(u_busy[0] || go_even) |=> !even_busy)
    else $error("even busy shown while idle");

endmodule

// ===== verilog/ics_pkg.sv
// Package: constants and types for the interleaved core storage control
package ics_pkg;

  localparam int CLK_MHZ        = 25;
  localparam int CYCLE_NS       = 6400;
  localparam int ACCESS_NS      = 2200;
  localparam int CLK_NS         = 1000 / CLK_MHZ;
  // Full cycle is a least time, access a longest time
  localparam int CYCLE_CLKS     = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CLKS    = (ACCESS_NS / CLK_NS < 1) ? 1 : ACCESS_NS / CLK_NS;
  // Read drive and sense window inside the access time
  localparam int SENSE_CLKS     = ACCESS_CLKS - 2;
  // Write drive phase stores the word halfway through the cycle
  localparam int WRITE_CLKS     = CYCLE_CLKS / 2;

  localparam int WORD_W         = 48;
  localparam int ADDR_W         = 15;
  localparam int UADDR_W        = 14;
  localparam int LINE_W         = 7;
  localparam int DEPTH          = 16384;
  localparam int CNT_W          = 8;
  localparam int UNIT_SEL_BIT   = 0;

  typedef enum logic [1:0] {
    ICS_SRC_OPERAND,
    ICS_SRC_PROGRAM,
    ICS_SRC_CHANNEL
  } ics_src_e;

  typedef enum logic [2:0] {
    ICS_IDLE,
    ICS_READ_DRIVE,
    ICS_DELIVER,
    ICS_CLEAR,
    ICS_WRITE_DRIVE
  } ics_state_e;

  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;

  // Pick the unit from the low address bit
  function automatic logic ics_is_odd(input logic [ADDR_W-1:0] a);
    return a[UNIT_SEL_BIT];
  endfunction

  // Drop the unit bit to form the unit-local location
  function automatic logic [UADDR_W-1:0] ics_local(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:UNIT_SEL_BIT+1];
  endfunction

endpackage

// ===== verilog/ics_unit.sv
// One storage unit: 128 x 128 matrix of 48-bit words with its own sequence
`timescale 1ns/1ns
module ics_unit
  import ics_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               req,
  input  wire logic               write,
  input  wire logic [UADDR_W-1:0] addr,
  input  wire logic [WORD_W-1:0]  wdata,
  output logic                    busy,
  output logic                    rvalid,
  output logic [WORD_W-1:0]       rdata,
  output logic [LINE_W-1:0]       row_sel,
  output logic [LINE_W-1:0]       col_sel,
  output logic                    drive_on,
  output logic [WORD_W-1:0]       inhibit
);

  typedef struct packed {
    ics_state_e           state;
    logic [CNT_W-1:0]     cnt;
    logic [UADDR_W-1:0]   loc;
    logic [WORD_W-1:0]    restore;
    logic                 wr;
    logic                 rvalid;
    logic [WORD_W-1:0]    rdata;
  } ics_unit_s;

  ics_unit_s st;
  ics_unit_s next_st;

  logic [WORD_W-1:0] planes [DEPTH];
  logic [WORD_W-1:0] sense;
  logic              sense_take;
  logic              plane_we;

  // Read drive leaves the location all zero, so every cycle must write back
  always_ff @(posedge clk) begin
    sense <= planes[st.loc];
    if (plane_we) begin
      planes[st.loc] <= st.restore;
    end else if (sense_take) begin
      planes[st.loc] <= '0;
    end
  end

  always_comb begin
    next_st    = st;
    next_st.rvalid = 1'b0;
    sense_take = 1'b0;
    plane_we   = 1'b0;
    next_st.cnt = CNT_W'(st.cnt + CNT_ONE);
    case (st.state)
      ICS_IDLE: begin
        next_st.cnt = CNT_ZERO;
        if (req) begin
          next_st.loc     = addr;
          next_st.wr      = write;
          next_st.restore = wdata;
          next_st.state   = write ? ICS_CLEAR : ICS_READ_DRIVE;
        end
      end
      ICS_READ_DRIVE: begin
        if (st.cnt == CNT_W'(SENSE_CLKS)) begin
          sense_take      = 1'b1;
          next_st.restore = sense;
          next_st.state   = ICS_DELIVER;
        end
      end
      ICS_DELIVER: begin
        if (st.cnt == CNT_W'(ACCESS_CLKS - 1)) begin
          next_st.rvalid = 1'b1;
          next_st.rdata  = st.restore;
          next_st.state  = ICS_WRITE_DRIVE;
        end
      end
      ICS_CLEAR: begin
        if (st.cnt == CNT_W'(SENSE_CLKS)) begin
          // Clear drive is a read drive whose sensed word is thrown away
          sense_take    = 1'b1;
          next_st.state = ICS_WRITE_DRIVE;
        end
      end
      ICS_WRITE_DRIVE: begin
        if (st.cnt == CNT_W'(WRITE_CLKS)) begin
          plane_we = 1'b1;
        end
        if (st.cnt == CNT_W'(CYCLE_CLKS - 1)) begin
          next_st.state = ICS_IDLE;
        end
      end
      default: next_st.state = ICS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  logic rd_drv;
  logic wr_drv;
  assign rd_drv   = (st.state == ICS_READ_DRIVE) || (st.state == ICS_CLEAR);
  assign wr_drv   = (st.state == ICS_WRITE_DRIVE);
  assign busy     = (st.state != ICS_IDLE);
  assign rvalid   = st.rvalid;
  assign rdata    = st.rdata;
  assign row_sel  = st.loc[UADDR_W-1:LINE_W];
  assign col_sel  = st.loc[LINE_W-1:0];
  assign drive_on = rd_drv | wr_drv;
  assign inhibit  = wr_drv ? ~st.restore : '0;

  clear_path_a: assert property (
    @(posedge clk) disable iff (!rst_n) (st.state == ICS_CLEAR) |-> st.wr)
    else $error("clear phase entered on a read");

  loc_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n) (st.state != ICS_IDLE) |=> $stable(st.loc))
    else $error("location changed mid cycle");

  sense_drive_a: assert property (
    @(posedge clk) disable iff (!rst_n) sense_take |-> rd_drv)
    else $error("sense taken without read drive");
endmodule

// ===== tb/ics_req_model.sv
// Requester model: shows the picked address source, hides the others
`timescale 1ns/1ns
module ics_req_model
  import ics_pkg::*;
(
  input  wire logic              go,
  input  wire logic              wr,
  input  wire logic [1:0]        src,
  input  wire logic [ADDR_W-1:0] a,
  input  wire logic [WORD_W-1:0] d,
  output logic                   req,
  output logic                   write,
  output logic [1:0]             src_sel,
  output logic [ADDR_W-1:0]      op_a,
  output logic [ADDR_W-1:0]      pg_a,
  output logic [ADDR_W-1:0]      ch_a,
  output logic [WORD_W-1:0]      wdata
);
  // Unpicked sources carry the inverse, so a wrong pick hits another place
  always_comb begin
    req     = go;
    write   = wr;
    src_sel = src;
    op_a    = (src == 2'h1 || src == 2'h2) ? ~a : a;
    pg_a    = (src == 2'h1) ? a : ~a;
    ch_a    = (src == 2'h2) ? a : ~a;
    wdata   = (go && wr) ? d : ~d;
  end
endmodule

// ===== tb/tb_top.sv
// Testbench: interleaved core storage control scenarios
`timescale 1ns/1ns
module tb_top;
  import ics_pkg::*;
  logic              clk   = 1'b0;
  logic              rst_n = 1'b0;
  logic              go    = 1'b0;
  logic              wr    = 1'b0;
  logic [1:0]        src   = 2'h0;
  logic [ADDR_W-1:0] a     = 15'h0000;
  logic [WORD_W-1:0] d     = 48'h0;
  logic              req, write, accept, refuse, rvalid, odd_busy, even_busy;
  logic [1:0]        src_sel;
  logic [ADDR_W-1:0] op_a, pg_a, ch_a;
  logic [WORD_W-1:0] wdata, rdata;
  int                err_total = 0;
  int                n_checks  = 0;
  logic [ADDR_W-1:0] ta [4] = '{15'h7fff, 15'h0000, 15'h0001, 15'h7ffe};
  logic [WORD_W-1:0] td [4] = '{48'hffff_ffff_ffff, 48'h0, 48'haaaa_aaaa_aaaa,
                                48'h5555_5555_5555};

  ics_req_model i_ics_req_model (.go(go), .wr(wr), .src(src), .a(a), .d(d),
    .req(req), .write(write), .src_sel(src_sel), .op_a(op_a), .pg_a(pg_a),
    .ch_a(ch_a), .wdata(wdata));
  ics_top i_ics_top (.clk(clk), .rst_n(rst_n), .req(req), .write(write),
    .src_sel(src_sel), .operand_address_source(op_a),
    .program_address_source(pg_a), .buffer_channel_address_source(ch_a),
    .wdata(wdata), .accept(accept), .refuse(refuse), .rvalid(rvalid),
    .rdata(rdata), .odd_busy(odd_busy), .even_busy(even_busy));

  initial begin
    forever #(CLK_NS / 2) clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [WORD_W-1:0] e,
                          input logic [WORD_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held one cycle only: holding it longer would be refused
  task automatic issue(input logic w, input logic [1:0] s,
                       input logic [ADDR_W-1:0] ad, input logic [WORD_W-1:0] dt);
    @(posedge clk);
    go  <= 1'b1;
    wr  <= w;
    src <= s;
    a   <= ad;
    d   <= dt;
    @(posedge clk);
    go  <= 1'b0;
    #1;
  endtask

  task automatic wait_rd(input logic [WORD_W-1:0] e);
    int n;
    n = 0;
    while (rvalid !== 1'b1 && n < ACCESS_CLKS + 3) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit("rvalid", 1'b1, rvalid);
    chk_word("rdata", e, rdata);
    @(posedge clk);
    #1;
  endtask

  task automatic idle(output int n);
    n = 0;
    while ((odd_busy | even_busy) !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit("busy", 1'b0, odd_busy | even_busy);
  endtask

  // Write via source i, read twice via source 3-i (codes 0 and 3 both pick operand): the restore must hold
  task automatic t_rw(input int i);
    int n;
    issue(1'b1, 2'(i), ta[i], td[i]);
    chk_bit("accept", 1'b1, accept);
    chk_bit("refuse", 1'b0, refuse);
    chk_bit("odd_busy", ta[i][0], odd_busy);
    chk_bit("even_busy", ~ta[i][0], even_busy);
    idle(n);
    chk_bit("cycle", 1'b1, n >= CYCLE_CLKS - 3 && n <= CYCLE_CLKS + 3);
    repeat (2) begin
      issue(1'b0, 2'(3 - i), ta[i], 48'h0);
      chk_bit("accept", 1'b1, accept);
      wait_rd(td[i]);
      idle(n);
    end
  endtask

  // Odd and even cycles overlap; a third request to the busy unit fails
  task automatic t_overlap();
    int n;
    issue(1'b0, 2'h0, ta[0], 48'h0);
    chk_bit("accept", 1'b1, accept);
    issue(1'b0, 2'h1, ta[3], 48'h0);
    chk_bit("accept", 1'b1, accept);
    chk_bit("both_busy", 1'b1, odd_busy & even_busy);
    issue(1'b1, 2'h2, ta[0], 48'h0);
    chk_bit("refuse", 1'b1, refuse);
    chk_bit("accept", 1'b0, accept);
    wait_rd(td[0]);
    // Even read was taken two edges after the odd one
    @(posedge clk);
    #1;
    chk_bit("rvalid", 1'b1, rvalid);
    chk_word("rdata", td[3], rdata);
    idle(n);
    issue(1'b0, 2'h0, ta[0], 48'h0);
    wait_rd(td[0]);
    idle(n);
  endtask

  initial begin
    #(CLK_NS * 20000);
    err_total++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_bit("accept", 1'b0, accept);
    chk_bit("busy", 1'b0, odd_busy | even_busy);
    for (int i = 0; i < 4; i++) begin
      t_rw(i);
    end
    t_overlap();
    conclude();
  end
endmodule
